// ---- rtl/olc_defines.vh ----
`ifndef OLC_DEFINES_VH
`define OLC_DEFINES_VH
// Register addresses, low seven bits of the serial address
`define OLC_A_PORT    7'h00
`define OLC_A_XFER    7'h01
`define OLC_A_NLO     7'h10
`define OLC_A_NHI     7'h11
`define OLC_A_CALP    7'h12
`define OLC_A_FA0     7'h14
`define OLC_A_FA1     7'h15
`define OLC_A_FA2     7'h16
`define OLC_A_FSH     7'h17
`define OLC_A_FBH     7'h18
`define OLC_A_MBL     7'h19
`define OLC_A_MBH     7'h1A
`define OLC_A_PUMP    7'h1E
`define OLC_A_REFD    7'h1F
`define OLC_A_MON     7'h20
`define OLC_A_CORELO  7'h6E
`define OLC_A_COREHI  7'h6F
`define OLC_A_LOCK    7'h7C
// Addresses of the plain storage registers beyond the monitor register
`define OLC_A_ODIV    7'h24
`define OLC_A_RFOC    7'h25
`define OLC_A_LKWIN   7'h27
`define OLC_A_LKCNT   7'h28
`define OLC_A_MODC    7'h2B
`define OLC_A_LCAL1   7'h2C
`define OLC_A_LCAL2   7'h2D
`define OLC_A_LCAL3   7'h2E
`define OLC_A_LCAL4   7'h2F
`define OLC_A_BCDIV   7'h30
`define OLC_A_WAITLO  7'h31
`define OLC_A_CONV    7'h32
`define OLC_A_SETTLE  7'h33
`define OLC_A_BIASW   7'h34
`define OLC_A_CCDIV   7'h35
`define OLC_A_POFS    7'h36
`define OLC_A_FBAND   7'h37
`define OLC_A_FCORE   7'h38
`define OLC_A_FTUNE   7'h39
`define OLC_A_COFS    7'h3A
`define OLC_A_RSV3E   7'h3E
`define OLC_A_RSV40   7'h40
`define OLC_A_RSV41   7'h41
`define OLC_A_RSV47   7'h47
`define OLC_A_RSV52   7'h52
`define OLC_A_AUXO    7'h72
`define OLC_A_DIVPWR  7'h73
// Reset values of the registers the logic knows by name
`define OLC_D_PORT    8'h18
`define OLC_D_NLO     8'h32
`define OLC_D_CALP    8'h40
`define OLC_D_MBL     8'hE8
`define OLC_D_MBH     8'h03
`define OLC_D_PUMP    8'h48
`define OLC_D_REFD    8'h01
`define OLC_D_MON     8'h14
// Reset values of the plain storage registers
`define OLC_D_ODIV    8'h80
`define OLC_D_RFOC    8'h07
`define OLC_D_LKWIN   8'hC5
`define OLC_D_LKCNT   8'h03
`define OLC_D_MODC    8'h01
`define OLC_D_LCAL1   8'h44
`define OLC_D_LCAL2   8'h11
`define OLC_D_LCAL3   8'h12
`define OLC_D_LCAL4   8'h94
`define OLC_D_BCDIV   8'h3F
`define OLC_D_WAITLO  8'hA7
`define OLC_D_CONV    8'h04
`define OLC_D_SETTLE  8'h0C
`define OLC_D_BIASW   8'h9E
`define OLC_D_CCDIV   8'h4C
`define OLC_D_POFS    8'h30
`define OLC_D_FTUNE   8'h07
`define OLC_D_COFS    8'h55
`define OLC_D_RSV3E   8'h80
`define OLC_D_RSV40   8'h50
`define OLC_D_RSV41   8'h28
`define OLC_D_RSV47   8'hC0
`define OLC_D_RSV52   8'hF4
`define OLC_D_AUXO    8'h32
`define OLC_D_ZERO    8'h00
// Writable bit masks; other bits keep their reset value
`define OLC_M_PORT    8'h0F
`define OLC_M_XFER    8'hE0
`define OLC_M_CALP    8'h60
`define OLC_M_FBH     8'h7F
`define OLC_M_MBH     8'h3F
`define OLC_M_PUMP    8'hFD
`define OLC_M_REFD    8'h1F
`define OLC_M_MON     8'hFC
`define OLC_M_FULL    8'hFF
`define OLC_M_NONE    8'h00
// Field positions
`define OLC_B_SOFTRST 0
`define OLC_B_LSBF    1
`define OLC_B_INCDIR  2
`define OLC_B_FOURW   3
`define OLC_B_SINGLE  7
`define OLC_B_CALON   6
`define OLC_B_PRESC   5
`define OLC_B_HOLD    0
`define OLC_B_SLEEP   2
`define OLC_B_POL     3
`define OLC_B_MONFN   3
`define OLC_F_DRIVE   7:4
`define OLC_F_MONSRC  7:4
`define OLC_F_REFDIV  4:0
`define OLC_F_FBHI    6:0
`define OLC_F_FSHA    7:1
`define OLC_F_MBHI    5:0
// Monitor source codes
`define OLC_MS_TRI    4'h0
`define OLC_MS_LOCK   4'h1
`define OLC_MS_UP     4'h2
`define OLC_MS_DOWN   4'h3
`define OLC_MS_REF    4'h4
`define OLC_MS_NDIV   4'h5
`define OLC_MS_VCOT   4'h6
`define OLC_MS_HIGH   4'h8
`define OLC_MS_CREF   4'h9
`define OLC_MS_CN     4'hA
// Monitor tap bit positions
`define OLC_T_UP      0
`define OLC_T_DOWN    1
`define OLC_T_REF     2
`define OLC_T_NDIV    3
`define OLC_T_VCOT    4
`define OLC_T_CREF    5
`define OLC_T_CN      6
// Serial framing
`define OLC_INSTR_LAST 4'hF
`define OLC_DATA_LAST  4'h7
`define OLC_BYTE_TOP   3'h7
`define OLC_ADDR_STEP  15'h0001
`define OLC_REG_COUNT  128
`endif

// ---- rtl/olc_register_bank.v ----
`timescale 1ns/1ns
`default_nettype none
`include "olc_defines.vh"

module olc_register_bank (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire        serialClk,
	input  wire        serialSelectN,
	input  wire        dataIn,
	output wire        dataOut,
	output wire        dataOe,
	output wire        monitorOut,
	output wire        monitorOe,
	input  wire        lockDetect,
	input  wire [6:0]  monitorTap,
	input  wire [15:0] coreReadback,
	output reg  [15:0] nWhole,
	output reg  [24:0] primaryFraction,
	output reg  [13:0] auxiliaryFraction,
	output reg  [13:0] auxiliaryModulus,
	output wire        bandCalibrationOn,
	output wire        prescaleEightNine,
	output wire [3:0]  pumpDriveCode,
	output wire        detectorPolarity,
	output wire        pllSleep,
	output wire        nCounterHold,
	output wire        refCounterHold,
	output wire [4:0]  refDivide
);

	// One-hot serial states
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_INSTR = 4'h2;
	localparam [3:0] ST_DATA  = 4'h4;
	localparam [3:0] ST_DONE  = 4'h8;
	// Modulus top field reset, sliced from its register default
	localparam [7:0] MOD_HIGH_RESET = `OLC_D_MBH;

	reg  [7:0]  regFile [0:`OLC_REG_COUNT-1];
	reg  [3:0]  state;
	reg  [3:0]  bitCnt;
	reg  [15:0] shiftWord;
	reg  [14:0] curAddr;
	reg         isRead;
	reg  [7:0]  rdByte;
	reg         outBit;
	reg         monitorReg;
	reg         sclkMeta;
	reg         sclkSync;
	reg         sclkLast;
	reg         selMeta;
	reg         selSync;
	reg         dinMeta;
	reg         dinSync;
	reg         lockMeta;
	reg         lockSync;
	integer     i;

	wire [7:0]  portCfg  = regFile[`OLC_A_PORT];
	wire        fourWireSelect     = portCfg[`OLC_B_FOURW];
	wire        incrementDirection = portCfg[`OLC_B_INCDIR];
	wire        lsbFirst           = portCfg[`OLC_B_LSBF];
	wire        singleTransfer = regFile[`OLC_A_XFER][`OLC_B_SINGLE];
	wire [7:0]  monCfg   = regFile[`OLC_A_MON];
	wire [3:0]  monitorPinSource   = monCfg[`OLC_F_MONSRC];
	wire        monitorPinFunction = monCfg[`OLC_B_MONFN];
	wire        sclkRise = sclkSync & ~sclkLast;
	wire        sclkFall = ~sclkSync & sclkLast;
	wire [15:0] next_shift;
	wire [7:0]  dataByte;
	wire [14:0] stepAddr;
	wire        readPhase;

	// Reset value of each register; unmapped addresses hold zero
	function [7:0] regDefault;
		input [6:0] a;
		begin
			case (a)
				`OLC_A_PORT: regDefault = `OLC_D_PORT;
				`OLC_A_NLO:  regDefault = `OLC_D_NLO;
				`OLC_A_CALP: regDefault = `OLC_D_CALP;
				`OLC_A_MBL:  regDefault = `OLC_D_MBL;
				`OLC_A_MBH:  regDefault = `OLC_D_MBH;
				`OLC_A_PUMP: regDefault = `OLC_D_PUMP;
				`OLC_A_REFD: regDefault = `OLC_D_REFD;
				`OLC_A_MON:  regDefault = `OLC_D_MON;
				`OLC_A_ODIV:   regDefault = `OLC_D_ODIV;
				`OLC_A_RFOC:   regDefault = `OLC_D_RFOC;
				`OLC_A_LKWIN:  regDefault = `OLC_D_LKWIN;
				`OLC_A_LKCNT:  regDefault = `OLC_D_LKCNT;
				`OLC_A_MODC:   regDefault = `OLC_D_MODC;
				`OLC_A_LCAL1:  regDefault = `OLC_D_LCAL1;
				`OLC_A_LCAL2:  regDefault = `OLC_D_LCAL2;
				`OLC_A_LCAL3:  regDefault = `OLC_D_LCAL3;
				`OLC_A_LCAL4:  regDefault = `OLC_D_LCAL4;
				`OLC_A_BCDIV:  regDefault = `OLC_D_BCDIV;
				`OLC_A_WAITLO: regDefault = `OLC_D_WAITLO;
				`OLC_A_CONV:   regDefault = `OLC_D_CONV;
				`OLC_A_SETTLE: regDefault = `OLC_D_SETTLE;
				`OLC_A_BIASW:  regDefault = `OLC_D_BIASW;
				`OLC_A_CCDIV:  regDefault = `OLC_D_CCDIV;
				`OLC_A_POFS:   regDefault = `OLC_D_POFS;
				`OLC_A_FTUNE:  regDefault = `OLC_D_FTUNE;
				`OLC_A_COFS:   regDefault = `OLC_D_COFS;
				`OLC_A_RSV3E:  regDefault = `OLC_D_RSV3E;
				`OLC_A_RSV40:  regDefault = `OLC_D_RSV40;
				`OLC_A_RSV41:  regDefault = `OLC_D_RSV41;
				`OLC_A_RSV47:  regDefault = `OLC_D_RSV47;
				`OLC_A_RSV52:  regDefault = `OLC_D_RSV52;
				`OLC_A_AUXO:   regDefault = `OLC_D_AUXO;
				default: regDefault = `OLC_D_ZERO;
			endcase
		end
	endfunction

	// Writable bits per address; zero mask makes a location read-only
	function [7:0] regMask;
		input [6:0] a;
		begin
			case (a)
				`OLC_A_PORT: regMask = `OLC_M_PORT;
				`OLC_A_XFER: regMask = `OLC_M_XFER;
				`OLC_A_CALP: regMask = `OLC_M_CALP;
				`OLC_A_FBH:  regMask = `OLC_M_FBH;
				`OLC_A_MBH:  regMask = `OLC_M_MBH;
				`OLC_A_PUMP: regMask = `OLC_M_PUMP;
				`OLC_A_REFD: regMask = `OLC_M_REFD;
				`OLC_A_MON:  regMask = `OLC_M_MON;
				`OLC_A_NLO, `OLC_A_NHI, `OLC_A_FA0, `OLC_A_FA1,
				`OLC_A_FA2, `OLC_A_FSH, `OLC_A_MBL,
				`OLC_A_ODIV, `OLC_A_RFOC, `OLC_A_LKWIN,
				`OLC_A_LKCNT, `OLC_A_MODC, `OLC_A_LCAL1,
				`OLC_A_LCAL2, `OLC_A_LCAL3, `OLC_A_LCAL4,
				`OLC_A_BCDIV, `OLC_A_WAITLO, `OLC_A_CONV,
				`OLC_A_SETTLE, `OLC_A_BIASW, `OLC_A_CCDIV,
				`OLC_A_POFS, `OLC_A_FBAND, `OLC_A_FCORE,
				`OLC_A_FTUNE, `OLC_A_COFS, `OLC_A_RSV3E,
				`OLC_A_RSV40, `OLC_A_RSV41, `OLC_A_RSV47,
				`OLC_A_RSV52, `OLC_A_AUXO, `OLC_A_DIVPWR:
					regMask = `OLC_M_FULL;
				default: regMask = `OLC_M_NONE;
			endcase
		end
	endfunction

	// Byte seen by a read; port config mirrors its low nibble reversed
	function [7:0] readValue;
		input [14:0] a;
		begin
			if (a[14:7] != 8'h00) begin
				readValue = `OLC_D_ZERO;
			end else begin
				case (a[6:0])
					`OLC_A_PORT: readValue = {portCfg[0], portCfg[1],
						portCfg[2], portCfg[3], portCfg[3:0]};
					`OLC_A_CORELO: readValue = coreReadback[7:0];
					`OLC_A_COREHI: readValue = coreReadback[15:8];
					`OLC_A_LOCK:   readValue = {7'h00, lockSync};
					default: readValue = regFile[a[6:0]];
				endcase
			end
		end
	endfunction

	// Bit of a byte at a serial position, in the chosen order
	function bitOf;
		input [7:0] b;
		input [2:0] idx;
		input       lsb;
		begin
			if (lsb) begin
				bitOf = b[idx];
			end else begin
				bitOf = b[`OLC_BYTE_TOP - idx];
			end
		end
	endfunction

	// Shift one serial bit into the frame word
	function [15:0] shiftNext;
		input [15:0] w;
		input        b;
		input        lsb;
		begin
			if (lsb) begin
				shiftNext = {b, w[15:1]};
			end else begin
				shiftNext = {w[14:0], b};
			end
		end
	endfunction

	// Frame word, byte and address step derived from the port setup
	assign next_shift = shiftNext(shiftWord, dinSync, lsbFirst);
	assign dataByte   = lsbFirst ? next_shift[15:8] : next_shift[7:0];
	assign stepAddr   = incrementDirection ?
		curAddr + `OLC_ADDR_STEP : curAddr - `OLC_ADDR_STEP;
	assign readPhase  = isRead & (state == ST_DATA) & ~selSync;

	// Pin inputs cross in through two flops; the first is read by nobody else
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sclkMeta <= 1'b0;
			sclkSync <= 1'b0;
			sclkLast <= 1'b0;
			selMeta  <= 1'b1;
			selSync  <= 1'b1;
			dinMeta  <= 1'b0;
			dinSync  <= 1'b0;
			lockMeta <= 1'b0;
			lockSync <= 1'b0;
		end else if (ce) begin
			sclkMeta <= serialClk;
			sclkSync <= sclkMeta;
			sclkLast <= sclkSync;
			selMeta  <= serialSelectN;
			selSync  <= selMeta;
			dinMeta  <= dataIn;
			dinSync  <= dinMeta;
			lockMeta <= lockDetect;
			lockSync <= lockMeta;
		end
	end

	// Serial frame engine, register file and applied N-counter words
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < `OLC_REG_COUNT; i = i + 1) begin
				regFile[i] <= regDefault(i[6:0]);
			end
			state     <= ST_IDLE;
			bitCnt    <= 4'h0;
			shiftWord <= 16'h0000;
			curAddr   <= 15'h0000;
			isRead    <= 1'b0;
			rdByte    <= 8'h00;
			outBit    <= 1'b0;
			nWhole            <= {`OLC_D_ZERO, `OLC_D_NLO};
			primaryFraction   <= 25'h0000000;
			auxiliaryFraction <= 14'h0000;
			auxiliaryModulus  <= {MOD_HIGH_RESET[`OLC_F_MBHI], `OLC_D_MBL};
		end else if (ce) begin
			if (selSync) begin
				// Select high aborts any frame in progress
				state  <= ST_IDLE;
				bitCnt <= 4'h0;
			end else if (sclkRise) begin
				case (state)
					ST_IDLE, ST_INSTR: begin
						shiftWord <= next_shift;
						if (bitCnt == `OLC_INSTR_LAST) begin
							isRead  <= next_shift[15];
							curAddr <= next_shift[14:0];
							rdByte  <= readValue(next_shift[14:0]);
							state   <= ST_DATA;
							bitCnt  <= 4'h0;
						end else begin
							state  <= ST_INSTR;
							bitCnt <= bitCnt + 4'h1;
						end
					end
					ST_DATA: begin
						shiftWord <= next_shift;
						if (bitCnt == `OLC_DATA_LAST) begin
							bitCnt <= 4'h0;
							if (!isRead && curAddr[14:7] == 8'h00) begin
								regFile[curAddr[6:0]] <=
									(dataByte & regMask(curAddr[6:0])) |
									(regFile[curAddr[6:0]] &
									~regMask(curAddr[6:0]));
							end
							// Low integer byte releases all shadowed words
							if (!isRead && curAddr == {8'h00, `OLC_A_NLO}) begin
								nWhole <= {regFile[`OLC_A_NHI],
									dataByte};
								primaryFraction <= {
									regFile[`OLC_A_FSH][0],
									regFile[`OLC_A_FA2],
									regFile[`OLC_A_FA1],
									regFile[`OLC_A_FA0]};
								auxiliaryFraction <= {
									regFile[`OLC_A_FBH][`OLC_F_FBHI],
									regFile[`OLC_A_FSH][`OLC_F_FSHA]};
								auxiliaryModulus <= {
									regFile[`OLC_A_MBH][`OLC_F_MBHI],
									regFile[`OLC_A_MBL]};
							end
							// Soft reset returns every register to default
							if (!isRead && curAddr == {8'h00, `OLC_A_PORT} &&
								dataByte[`OLC_B_SOFTRST]) begin
								for (i = 0; i < `OLC_REG_COUNT; i = i + 1) begin
									regFile[i] <= regDefault(i[6:0]);
								end
							end
							if (singleTransfer) begin
								state <= ST_DONE;
							end else begin
								curAddr <= stepAddr;
								rdByte  <= readValue(stepAddr);
							end
						end else begin
							bitCnt <= bitCnt + 4'h1;
						end
					end
					ST_DONE: begin
						state <= ST_DONE;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
			// Read data moves on the falling edge, host samples on rising
			if (sclkFall) begin
				outBit <= bitOf(rdByte, bitCnt[2:0], lsbFirst);
			end
		end
	end

	// Monitor signal select, registered so the pin sees no decode glitches
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			monitorReg <= 1'b0;
		end else if (ce) begin
			case (monitorPinSource)
				`OLC_MS_LOCK: monitorReg <= lockSync;
				`OLC_MS_UP:   monitorReg <= monitorTap[`OLC_T_UP];
				`OLC_MS_DOWN: monitorReg <= monitorTap[`OLC_T_DOWN];
				`OLC_MS_REF:  monitorReg <= monitorTap[`OLC_T_REF];
				`OLC_MS_NDIV: monitorReg <= monitorTap[`OLC_T_NDIV];
				`OLC_MS_VCOT: monitorReg <= monitorTap[`OLC_T_VCOT];
				`OLC_MS_HIGH: monitorReg <= 1'b1;
				`OLC_MS_CREF: monitorReg <= monitorTap[`OLC_T_CREF];
				`OLC_MS_CN:   monitorReg <= monitorTap[`OLC_T_CN];
				default:      monitorReg <= 1'b0;
			endcase
		end
	end

	// Three-wire reads turn the data pin around during the data phase
	assign dataOut = outBit;
	assign dataOe  = readPhase & ~fourWireSelect;

	// Monitor pin: four-wire read output or monitor signal
	assign monitorOut = monitorPinFunction ? monitorReg : outBit;
	assign monitorOe  = monitorPinFunction |
		(readPhase & fourWireSelect &
		(monitorPinSource != `OLC_MS_TRI));

	// Controls steering the calibration loop
	assign bandCalibrationOn = regFile[`OLC_A_CALP][`OLC_B_CALON];
	assign prescaleEightNine = regFile[`OLC_A_CALP][`OLC_B_PRESC];
	assign pumpDriveCode     = regFile[`OLC_A_PUMP][`OLC_F_DRIVE];
	assign detectorPolarity  = regFile[`OLC_A_PUMP][`OLC_B_POL];
	// Sleep only gates the loop; register contents are untouched
	assign pllSleep          = regFile[`OLC_A_PUMP][`OLC_B_SLEEP];
	assign nCounterHold      = regFile[`OLC_A_PUMP][`OLC_B_HOLD];
	assign refCounterHold    = regFile[`OLC_A_PUMP][`OLC_B_HOLD];
	assign refDivide         = regFile[`OLC_A_REFD][`OLC_F_REFDIV];

endmodule

`default_nettype wire

// ---- bench/olc_bank_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module olc_bank_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        serialClk,
	input wire logic        serialSelectN,
	input wire logic        dataOe,
	input wire logic [15:0] nWhole,
	input wire logic [24:0] primaryFraction,
	input wire logic [13:0] auxiliaryFraction,
	input wire logic [13:0] auxiliaryModulus,
	input wire logic [3:0]  pumpDriveCode,
	input wire logic [4:0]  refDivide,
	input wire logic        nCounterHold,
	input wire logic        refCounterHold
);
	logic [7:0] riseCnt;
	logic [3:0] idleCnt;
	logic       sclkPrev;
	logic       selPrev;
	// Rise count survives the frame end, since updates land a few clocks late
	// Pin edges come from last-cycle copies, safe under the async reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			riseCnt  <= 8'h00;
			idleCnt  <= 4'h0;
			sclkPrev <= 1'b0;
			selPrev  <= 1'b1;
		end else begin
			sclkPrev <= serialClk;
			selPrev  <= serialSelectN;
			if (selPrev && !serialSelectN)
				riseCnt <= 8'h00;
			else if (serialClk && !sclkPrev && !serialSelectN)
				riseCnt <= riseCnt + 8'h01;
			if (!serialSelectN)
				idleCnt <= 4'h0;
			else if (idleCnt != 4'hF)
				idleCnt <= idleCnt + 4'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Select high long enough for the pin synchronisers to drain
	sequence s_idle;
		serialSelectN [*8];
	endsequence
	// Instruction plus one whole data byte seen
	sequence s_data_byte;
		riseCnt >= 8'h18;
	endsequence
	a_hold_pair: assert property (nCounterHold == refCounterHold)
		else $error("Counter holds differ");
	a_oe_idle: assert property (s_idle |-> !dataOe)
		else $error("Data pin driven outside a frame");
	a_oe_after_instr: assert property (dataOe |-> riseCnt >= 8'h10)
		else $error("Data pin driven before instruction end");
	a_whole_held: assert property (idleCnt == 4'hF |-> $stable(nWhole))
		else $error("Applied integer moved while idle");
	a_whole_needs_byte: assert property ($changed(nWhole) |-> s_data_byte)
		else $error("Applied integer moved without a data byte");
	a_frac_needs_byte: assert property ($changed(primaryFraction)
		|-> s_data_byte) else $error("Fraction moved without a data byte");
	a_aux_needs_byte: assert property (
		$changed({auxiliaryFraction, auxiliaryModulus}) |-> s_data_byte)
		else $error("Auxiliary words moved without a data byte");
	a_ctrl_held: assert property (idleCnt == 4'hF
		|-> $stable({pumpDriveCode, refDivide}))
		else $error("Control levels moved while idle");
	a_ctrl_needs_byte: assert property (
		$changed({pumpDriveCode, refDivide}) |-> s_data_byte)
		else $error("Control levels moved without a data byte");
endmodule
bind olc_register_bank olc_bank_monitor monitor (.clk(clk), .rst(rst),
	.serialClk(serialClk), .serialSelectN(serialSelectN), .dataOe(dataOe),
	.nWhole(nWhole), .primaryFraction(primaryFraction),
	.auxiliaryFraction(auxiliaryFraction), .auxiliaryModulus(auxiliaryModulus),
	.pumpDriveCode(pumpDriveCode), .refDivide(refDivide),
	.nCounterHold(nCounterHold), .refCounterHold(refCounterHold));
`default_nettype wire

// ---- bench/olc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module olc_host_model (
	input  wire logic clk,
	output var logic  serialClk,
	output var logic  serialSelectN,
	output var logic  hostData,
	input  wire logic dataOut,
	input  wire logic dataOe,
	input  wire logic monitorOut,
	input  wire logic monitorOe
);
	logic lsbFirst;
	logic threeWire;
	// Clock idles low and stands still between frames
	initial begin
		serialClk = 1'b0;
		serialSelectN = 1'b1;
		hostData = 1'b0;
		lsbFirst = 1'b0;
		threeWire = 1'b0;
	end
	// Six clocks per level keeps each level above the synchroniser limit
	task automatic shiftBit(input logic b, input logic drv, output logic r);
		@(posedge clk);
		serialClk <= 1'b0;
		hostData <= drv ? b : ~hostData;
		repeat (6) @(posedge clk);
		// A pin that nobody drives reads back inverted, so a float shows
		r = threeWire ? (dataOe ? dataOut : ~dataOut)
			: (monitorOe ? monitorOut : ~monitorOut);
		serialClk <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
	task automatic frame(input logic rd, input logic [14:0] a, input int n,
			input logic [31:0] wd, output logic [31:0] rdo);
		logic [15:0] ins;
		logic        r;
		int          i;
		int          k;
		ins = {rd, a};
		rdo = 32'h0;
		@(posedge clk);
		serialSelectN <= 1'b0;
		repeat (6) @(posedge clk);
		for (i = 0; i < 16; i++)
			shiftBit(ins[lsbFirst ? i : 15 - i], 1'b1, r);
		for (i = 0; i < 8 * n; i++) begin
			k = lsbFirst ? i : (i / 8) * 8 + 7 - i % 8;
			shiftBit(wd[k], !(rd && threeWire), r);
			rdo[k] = r;
		end
		@(posedge clk);
		serialClk <= 1'b0;
		repeat (3) @(posedge clk);
		serialSelectN <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic             clk, rst, ce, lockDetect;
	logic [6:0]       monitorTap;
	logic [15:0]      coreReadback, monVec;
	logic [31:0]      rdData;
	int               miscompares, testsRun, i, p;
	wire logic        serialClk, serialSelectN, hostData, dataIn;
	wire logic        dataOut, dataOe, monitorOut, monitorOe;
	wire logic        bandCalibrationOn, prescaleEightNine, detectorPolarity;
	wire logic        pllSleep, nCounterHold, refCounterHold;
	wire logic [3:0]  pumpDriveCode;
	wire logic [4:0]  refDivide;
	wire logic [15:0] nWhole, ctrlOut;
	wire logic [24:0] primaryFraction;
	wire logic [13:0] auxiliaryFraction, auxiliaryModulus;
	// Address, write data, read-back and control levels after each write
	logic [7:0] wA [20] = '{8'h12, 8'h1E, 8'h1F, 8'h1E, 8'h12, 8'h1F, 8'h01,
		8'h1E, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
		8'h05, 8'h7C, 8'h6E};
	logic [7:0] wD [20] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hE0, 8'h1F,
		8'h58, 8'h32, 8'h12, 8'h56, 8'h34, 8'h12, 8'h03, 8'hD5, 8'hAB, 8'hFF,
		8'h77, 8'hFF, 8'h00};
	logic [7:0] wR [20] = '{8'h60, 8'hFD, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h58, 8'h32, 8'h12, 8'h56, 8'h34, 8'h12, 8'h03, 8'h55, 8'hAB, 8'h3F,
		8'h00, 8'h00, 8'h5A};
	logic [15:0] wC [20] = '{0: 16'hD201, 1: 16'hFFC1, 2: 16'hFFDF,
		3: 16'hC01F, 4: 16'h001F, 5: 16'h0000, 6: 16'h0000, default: 16'h1600};
	// Pin level seen by the device: its own drive wins during read data
	assign dataIn = dataOe ? dataOut : hostData;
	assign ctrlOut = {bandCalibrationOn, prescaleEightNine, pumpDriveCode,
		detectorPolarity, pllSleep, nCounterHold, refCounterHold, 1'b0,
		refDivide};
	olc_register_bank dut (.clk(clk), .rst(rst), .ce(ce),
		.serialClk(serialClk), .serialSelectN(serialSelectN), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .monitorOut(monitorOut),
		.monitorOe(monitorOe), .lockDetect(lockDetect),
		.monitorTap(monitorTap), .coreReadback(coreReadback), .nWhole(nWhole),
		.primaryFraction(primaryFraction), .auxiliaryFraction(auxiliaryFraction),
		.auxiliaryModulus(auxiliaryModulus),
		.bandCalibrationOn(bandCalibrationOn),
		.prescaleEightNine(prescaleEightNine), .pumpDriveCode(pumpDriveCode),
		.detectorPolarity(detectorPolarity), .pllSleep(pllSleep),
		.nCounterHold(nCounterHold), .refCounterHold(refCounterHold),
		.refDivide(refDivide));
	olc_host_model host (.clk(clk), .serialClk(serialClk),
		.serialSelectN(serialSelectN), .hostData(hostData), .dataOut(dataOut),
		.dataOe(dataOe), .monitorOut(monitorOut), .monitorOe(monitorOe));
	// 10 MHz clock
	initial clk = 1'b0;
	always #50 clk = ~clk;
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.frame(1'b0, {7'h00, a}, 1, {24'h0, d}, rdData);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		host.frame(1'b1, {7'h00, a}, 1, 32'h0, rdData);
		check({24'h0, rdData[7:0]}, {24'h0, e});
	endtask
	task automatic results();
		$display("Checks run %0d, mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, well beyond the roughly 30000 clocks the tests need
	initial begin
		repeat (80000) @(posedge clk);
		miscompares++;
		results();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		lockDetect = 1'b0;
		monitorTap = 7'h00;
		coreReadback = 16'hA55A;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		check({auxiliaryModulus, 2'b00, nWhole}, 32'h0FA0_0032);
		check({16'h0, ctrlOut}, 32'h0000_9201);
		rdchk(8'h00, 8'h18);
		rdchk(8'h1F, 8'h01);
		rdchk(8'h20, 8'h14);
		// Field writes, reserved bits, read-only places and shadow loads
		for (i = 0; i < 20; i++) begin
			wr(wA[i], wD[i]);
			rdchk(wA[i], wR[i]);
			check({16'h0, ctrlOut}, {16'h0, wC[i]});
		end
		check({7'h0, primaryFraction}, 32'h0);
		wr(8'h10, 8'h78);
		check({auxiliaryModulus, 2'b00, nWhole}, 32'hFEAC_1278);
		check({7'h0, primaryFraction}, 32'h0112_3456);
		check({18'h0, auxiliaryFraction}, 32'h0000_2A81);
		// Bursts: descending by default, then ascending, then single transfer
		host.frame(1'b0, 15'h0011, 2, 32'h0000_BBAA, rdData);
		check({16'h0, nWhole}, 32'h0000_AABB);
		wr(8'h00, 8'h0C);
		host.frame(1'b0, 15'h0014, 3, 32'h0033_2211, rdData);
		host.frame(1'b1, 15'h0014, 3, 32'h0, rdData);
		check({8'h0, rdData[23:0]}, 32'h0033_2211);
		wr(8'h01, 8'h80);
		host.frame(1'b0, 15'h0014, 2, 32'h0000_5544, rdData);
		wr(8'h01, 8'h00);
		rdchk(8'h14, 8'h44);
		rdchk(8'h15, 8'h22);
		// Least significant bit first, both directions
		wr(8'h00, 8'h0E);
		host.lsbFirst = 1'b1;
		wr(8'h1F, 8'h05);
		rdchk(8'h1F, 8'h05);
		rdchk(8'h00, 8'h7E);
		wr(8'h00, 8'h0C);
		host.lsbFirst = 1'b0;
		rdchk(8'h1F, 8'h05);
		// Three-wire reads come back on the shared data pin
		wr(8'h00, 8'h04);
		host.threeWire = 1'b1;
		rdchk(8'h00, 8'h24);
		rdchk(8'h1F, 8'h05);
		check({31'h0, dataOe}, 32'h0);
		wr(8'h00, 8'h0C);
		host.threeWire = 1'b0;
		// Every monitor source code, with the taps in both polarities
		for (p = 0; p < 2; p++) begin
			lockDetect <= p[0];
			monitorTap <= p[0] ? 7'h2A : 7'h55;
			for (i = 0; i < 11; i++) begin
				wr(8'h20, {i[3:0], 4'hC});
				monVec = {5'h00, monitorTap[6:5], 2'b10, monitorTap[4:0],
					lockDetect, 1'b0};
				check({30'h0, monitorOe, monitorOut}, {30'h1, monVec[i]});
			end
		end
		wr(8'h20, 8'h04);
		check({31'h0, monitorOe}, 32'h0);
		rdchk(8'h1F, 8'hFA);
		wr(8'h20, 8'h14);
		rdchk(8'h7C, 8'h01);
		// Clock enable low freezes the bank, so a whole frame goes unseen
		ce <= 1'b0;
		wr(8'h1F, 8'h0A);
		ce <= 1'b1;
		rdchk(8'h1F, 8'h05);
		// Soft reset restores registers but not the applied words
		wr(8'h00, 8'h19);
		rdchk(8'h1F, 8'h01);
		rdchk(8'h00, 8'h18);
		check({nWhole, ctrlOut}, 32'hAABB_9201);
		results();
	end
endmodule
`default_nettype wire
